// ===== src/ser_pkg.sv
package ser_pkg;
	// ==========================================================
	// Register map.
	localparam logic [3:0] ADDR_SECT_COUNT = 4'h0;
	localparam logic [3:0] ADDR_ID_SECTOR = 4'h1;
	localparam logic [3:0] ADDR_SEQ_STATUS = 4'h2;
	localparam logic [3:0] ADDR_RESTART = 4'h3;
	localparam logic [3:0] ADDR_ECC_STATUS = 4'h4;
	localparam logic [3:0] ADDR_SYND_PORT = 4'h5;
	localparam logic [3:0] ADDR_ECC_CONFIG = 4'h6;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'h7;
	localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h8;
	localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h9;
	localparam logic [3:0] ADDR_RESTART_LAST = 4'ha;
	// ==========================================================
	// Field positions.
	localparam int SEQ_SYNC_BIT = 0;
	localparam int SEQ_CMP_BIT = 1;
	localparam int SEQ_CKS_BIT = 2;
	localparam int SEQ_RUN_BIT = 3;
	localparam int ECC_SUMMARY_BIT = 7;
	localparam int IRQ_HALT_BIT = 0;
	localparam int IRQ_DONE_BIT = 1;
	// ==========================================================
	// Reset values and code sizes.
	localparam logic [7:0] SECT_COUNT_RST = 8'h00;
	localparam logic [7:0] RESTART_RST = 8'h00;
	localparam int NUM_INTERLEAVE = 5;
	localparam int DEG_LOW = 5;
	localparam int DEG_HIGH = 6;
	localparam int CORR_LOW = 2;
	localparam int CORR_HIGH = 3;
	localparam int MAX_CORR_BYTES = 30;
	// ==========================================================
	// Halt causes reported by the sequencer.
	typedef enum logic [2:0]
	{
		SER_ERR_NONE = 3'b000,
		SER_ERR_ID = 3'b001,
		SER_ERR_SYNC = 3'b010,
		SER_ERR_CMP = 3'b011,
		SER_ERR_CKS = 3'b100
	} ser_err_e;
	typedef enum logic [1:0]
	{
		SER_IDLE = 2'b00,
		SER_RUN = 2'b01,
		SER_HALT = 2'b10
	} ser_state_e;
	// Sequencer event reported for each sector.
	typedef struct packed
	{
		logic sector_done;
		logic halt;
		ser_err_e cause;
		logic data_xfer;
	} ser_evt_s;
	// Register bus request.
	typedef struct packed
	{
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} ser_bus_s;
endpackage : ser_pkg

// ===== src/ser_error_recovery.sv
// ==========================================================
`timescale 1ns/1ps
`default_nettype none
module ser_error_recovery #(
	parameter int NUM_IL = ser_pkg::NUM_INTERLEAVE,
	parameter int MAX_DEG = ser_pkg::DEG_HIGH
)(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire ser_pkg::ser_evt_s seq_evt,
	input wire logic [7:0] id_sector_in,
	input wire logic synd_load,
	input wire logic [NUM_IL*MAX_DEG*8-1:0] synd_in,
	input wire logic [NUM_IL-1:0] synd_err_in,
	output logic seq_start,
	output logic [7:0] restart_addr,
	output logic sequencer_running,
	output logic irq
);
	// ==========================================================
	// Reset release.
	logic rst_meta_q;
	logic rst_sync_q;
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// ==========================================================
	// Sequencer halt and recovery state.
	ser_pkg::ser_state_e state_q, state_d;
	logic [7:0] sector_remaining_count_q, sector_remaining_count_d;
	logic [7:0] id_sector_q, id_sector_d;
	logic sync_error_flag_q, sync_error_flag_d;
	logic compare_error_flag_q, compare_error_flag_d;
	logic checksum_error_flag_q, checksum_error_flag_d;
	logic [7:0] restart_addr_q, restart_addr_d;
	logic seq_start_q, seq_start_d;
	logic [NUM_IL-1:0] il_err_q, il_err_d;
	logic [NUM_IL*MAX_DEG*8-1:0] synd_q, synd_d;
	logic [2:0] byte_ptr_q, byte_ptr_d;
	logic deg6_q, deg6_d;
	logic [1:0] irq_stat_q, irq_stat_d;
	logic [1:0] irq_en_q, irq_en_d;
	logic [7:0] rdata_q, rdata_d;
	logic irq_q, irq_d;
	logic running_q, running_d;
	logic err_latched;
	logic past_failed;
	logic [2:0] cur_il;
	logic [2:0] last_byte;
	logic [7:0] synd_byte;

	assign err_latched = sync_error_flag_q | compare_error_flag_q | checksum_error_flag_q;
	// ID and sync halts keep the failed sector unless data transfer had already begun.
	assign past_failed = seq_evt.data_xfer
		| ((seq_evt.cause != ser_pkg::SER_ERR_ID) && (seq_evt.cause != ser_pkg::SER_ERR_SYNC));
	assign last_byte = deg6_q ? 3'(ser_pkg::DEG_HIGH - 1) : 3'(ser_pkg::DEG_LOW - 1);

	// Lowest-numbered failing interleave is the one offered.
	always_comb
	begin
		cur_il = 3'h0;
		for (int i = NUM_IL - 1; i >= 0; i--)
		begin
			if (il_err_q[i])
			begin
				cur_il = 3'(i);
			end
		end
	end

	// Byte zero of each interleave slot is its least significant syndrome byte.
	always_comb
	begin
		synd_byte = synd_q[(int'(cur_il) * MAX_DEG + int'(byte_ptr_q)) * 8 +: 8];
	end

	// Next-state for registers, flags, syndromes and the read port.
	always_comb
	begin
		state_d = state_q;
		sector_remaining_count_d = sector_remaining_count_q;
		id_sector_d = id_sector_q;
		sync_error_flag_d = sync_error_flag_q;
		compare_error_flag_d = compare_error_flag_q;
		checksum_error_flag_d = checksum_error_flag_q;
		restart_addr_d = restart_addr_q;
		seq_start_d = 1'b0;
		il_err_d = il_err_q;
		synd_d = synd_q;
		byte_ptr_d = byte_ptr_q;
		deg6_d = deg6_q;
		irq_stat_d = irq_stat_q;
		irq_en_d = irq_en_q;
		rdata_d = 8'h00;
		// Register writes come first so hardware events below win on the same cycle.
		if (reg_wr)
		begin
			if (reg_addr == ser_pkg::ADDR_SECT_COUNT)
			begin
				sector_remaining_count_d = reg_wdata;
				// A latched error keeps a fresh count from starting anything.
				if ((reg_wdata != 8'h00) && !err_latched && (state_q == ser_pkg::SER_IDLE))
				begin
					state_d = ser_pkg::SER_RUN;
					seq_start_d = 1'b1;
				end
			end
			else if (reg_addr == ser_pkg::ADDR_ID_SECTOR)
			begin
				id_sector_d = reg_wdata;
			end
			else if (reg_addr == ser_pkg::ADDR_RESTART)
			begin
				restart_addr_d = reg_wdata;
				sync_error_flag_d = 1'b0;
				compare_error_flag_d = 1'b0;
				checksum_error_flag_d = 1'b0;
				if (sector_remaining_count_q != 8'h00)
				begin
					state_d = ser_pkg::SER_RUN;
					seq_start_d = 1'b1;
				end
				else
				begin
					state_d = ser_pkg::SER_IDLE;
				end
			end
			else if (reg_addr == ser_pkg::ADDR_ECC_STATUS)
			begin
				// Only a written zero clears a flag; the pointer restarts for the next one.
				il_err_d = il_err_q & reg_wdata[NUM_IL-1:0];
				if ((il_err_q & ~reg_wdata[NUM_IL-1:0]) != '0)
				begin
					byte_ptr_d = 3'h0;
				end
			end
			else if (reg_addr == ser_pkg::ADDR_ECC_CONFIG)
			begin
				deg6_d = reg_wdata[0];
			end
			else if (reg_addr == ser_pkg::ADDR_IRQ_ENABLE)
			begin
				irq_en_d = reg_wdata[1:0];
			end
			else if (reg_addr == ser_pkg::ADDR_IRQ_CLEAR)
			begin
				irq_stat_d = irq_stat_q & ~reg_wdata[1:0];
			end
		end
		// Register reads; the port read also steps the byte pointer.
		if (reg_rd)
		begin
			if (reg_addr == ser_pkg::ADDR_SECT_COUNT)
			begin
				rdata_d = sector_remaining_count_q;
			end
			else if (reg_addr == ser_pkg::ADDR_ID_SECTOR)
			begin
				rdata_d = id_sector_q;
			end
			else if (reg_addr == ser_pkg::ADDR_SEQ_STATUS)
			begin
				rdata_d[ser_pkg::SEQ_SYNC_BIT] = sync_error_flag_q;
				rdata_d[ser_pkg::SEQ_CMP_BIT] = compare_error_flag_q;
				rdata_d[ser_pkg::SEQ_CKS_BIT] = checksum_error_flag_q;
				rdata_d[ser_pkg::SEQ_RUN_BIT] = (state_q == ser_pkg::SER_RUN);
			end
			else if (reg_addr == ser_pkg::ADDR_RESTART_LAST)
			begin
				rdata_d = restart_addr_q;
			end
			else if (reg_addr == ser_pkg::ADDR_ECC_STATUS)
			begin
				rdata_d[NUM_IL-1:0] = il_err_q;
				rdata_d[ser_pkg::ECC_SUMMARY_BIT] = |il_err_q;
			end
			else if (reg_addr == ser_pkg::ADDR_SYND_PORT)
			begin
				if (il_err_q != '0)
				begin
					rdata_d = synd_byte;
					if (byte_ptr_q != last_byte)
					begin
						byte_ptr_d = byte_ptr_q + 3'h1;
					end
				end
			end
			else if (reg_addr == ser_pkg::ADDR_ECC_CONFIG)
			begin
				rdata_d[0] = deg6_q;
			end
			else if (reg_addr == ser_pkg::ADDR_IRQ_STATUS)
			begin
				rdata_d[1:0] = irq_stat_q;
			end
			else if (reg_addr == ser_pkg::ADDR_IRQ_ENABLE)
			begin
				rdata_d[1:0] = irq_en_q;
			end
		end
		// Syndromes are captured at the end of each read data field.
		if (synd_load)
		begin
			synd_d = synd_in;
			il_err_d = synd_err_in;
			byte_ptr_d = 3'h0;
		end
		// Sequencer events while running.
		if (state_q == ser_pkg::SER_RUN)
		begin
			if (seq_evt.halt)
			begin
				state_d = ser_pkg::SER_HALT;
				irq_stat_d[ser_pkg::IRQ_HALT_BIT] = 1'b1;
				sync_error_flag_d = sync_error_flag_q | (seq_evt.cause == ser_pkg::SER_ERR_SYNC);
				compare_error_flag_d = compare_error_flag_q | (seq_evt.cause == ser_pkg::SER_ERR_CMP);
				checksum_error_flag_d = checksum_error_flag_q | (seq_evt.cause == ser_pkg::SER_ERR_CKS);
				if (past_failed)
				begin
					sector_remaining_count_d = sector_remaining_count_q - 8'h01;
				end
				// Only a sync halt before data transfer keeps the failed address.
				if (seq_evt.data_xfer || (seq_evt.cause != ser_pkg::SER_ERR_SYNC))
				begin
					id_sector_d = id_sector_in + 8'h01;
				end
				else
				begin
					id_sector_d = id_sector_in;
				end
				// ID and sync halts before data leave the count untouched.
				if (!past_failed)
				begin
					sector_remaining_count_d = sector_remaining_count_q;
				end
			end
			else if (seq_evt.sector_done)
			begin
				sector_remaining_count_d = sector_remaining_count_q - 8'h01;
				id_sector_d = id_sector_in + 8'h01;
				if (sector_remaining_count_q == 8'h01)
				begin
					state_d = ser_pkg::SER_IDLE;
					irq_stat_d[ser_pkg::IRQ_DONE_BIT] = 1'b1;
				end
			end
		end
		running_d = (state_d == ser_pkg::SER_RUN);
		irq_d = |(irq_stat_d & irq_en_d);
	end

	// Register all state.
	always_ff @(posedge sys_clk or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
		begin
			state_q <= ser_pkg::SER_IDLE;
			sector_remaining_count_q <= ser_pkg::SECT_COUNT_RST;
			id_sector_q <= 8'h00;
			sync_error_flag_q <= 1'b0;
			compare_error_flag_q <= 1'b0;
			checksum_error_flag_q <= 1'b0;
			restart_addr_q <= ser_pkg::RESTART_RST;
			seq_start_q <= 1'b0;
			il_err_q <= '0;
			synd_q <= '0;
			byte_ptr_q <= 3'h0;
			deg6_q <= 1'b1;
			irq_stat_q <= 2'h0;
			irq_en_q <= 2'h0;
			rdata_q <= 8'h00;
			irq_q <= 1'b0;
			running_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			sector_remaining_count_q <= sector_remaining_count_d;
			id_sector_q <= id_sector_d;
			sync_error_flag_q <= sync_error_flag_d;
			compare_error_flag_q <= compare_error_flag_d;
			checksum_error_flag_q <= checksum_error_flag_d;
			restart_addr_q <= restart_addr_d;
			seq_start_q <= seq_start_d;
			il_err_q <= il_err_d;
			synd_q <= synd_d;
			byte_ptr_q <= byte_ptr_d;
			deg6_q <= deg6_d;
			irq_stat_q <= irq_stat_d;
			irq_en_q <= irq_en_d;
			rdata_q <= rdata_d;
			irq_q <= irq_d;
			running_q <= running_d;
		end
	end

	// ==========================================================
	// Outputs, all registered.
	assign reg_rdata = rdata_q;
	assign seq_start = seq_start_q;
	assign restart_addr = restart_addr_q;
	assign sequencer_running = running_q;
	assign irq = irq_q;
endmodule : ser_error_recovery
`default_nettype wire

// ===== bench/ser_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// =====
// Host processor model: register bus master and the correction routine.
module ser_host_model (
	input wire logic sys_clk,
	input wire logic [7:0] reg_rdata,
	output logic [3:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd
);
	// The bus idles with both strobes low.
	initial
	begin
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// One-cycle write; the slave never stalls the master.
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe.
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd

	// Service the lowest failing interleave; extra reads probe the pointer hold.
	task automatic fetch(input int deg, input int extra, output logic [7:0] e,
		output logic [7:0] b [8]);
		logic [7:0] d;
		logic [4:0] low;
		rd(ser_pkg::ADDR_IRQ_STATUS, d);
		rd(ser_pkg::ADDR_ECC_STATUS, e);
		low = e[4:0] & (~e[4:0] + 5'h01);
		for (int j = 0; j < deg + extra; j++)
			rd(ser_pkg::ADDR_SYND_PORT, b[j]);
		wr(ser_pkg::ADDR_ECC_STATUS, {3'h0, e[4:0] & ~low});
	endtask : fetch
endmodule : ser_host_model
`default_nettype wire

// ===== bench/ser_error_recovery_checker.sv
`timescale 1ns/1ps
`default_nettype none
// =====
// Port checks for the error recovery block.
module ser_error_recovery_checker #(
	parameter int NUM_IL = 5,
	parameter int MAX_DEG = 6
)(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire ser_pkg::ser_evt_s seq_evt,
	input wire logic seq_start,
	input wire logic [7:0] restart_addr,
	input wire logic sequencer_running,
	input wire logic irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	// A start only ever follows a count or restart write, never a latched error.
	halt_stops_a: assert property (seq_evt.halt && sequencer_running |=> !sequencer_running)
		else $error("sequencer kept running after a halt");
	start_cause_a: assert property (seq_start |-> $past(reg_wr) &&
		($past(reg_addr) == ser_pkg::ADDR_RESTART || $past(reg_addr) == ser_pkg::ADDR_SECT_COUNT))
		else $error("sequencer started without a write");
	start_pulse_a: assert property (seq_start |=> !seq_start)
		else $error("start pulse longer than one cycle");
	start_runs_a: assert property (seq_start |-> ##[0:1] sequencer_running)
		else $error("start did not run the sequencer");
	restart_addr_a: assert property (reg_wr && reg_addr == ser_pkg::ADDR_RESTART
		|=> restart_addr == $past(reg_wdata)) else $error("restart address not taken");
	readback_a: assert property (reg_rd && reg_addr == ser_pkg::ADDR_RESTART_LAST
		|=> reg_rdata == restart_addr) else $error("restart readback wrong");
	run_bit_a: assert property (reg_rd && reg_addr == ser_pkg::ADDR_SEQ_STATUS
		|=> reg_rdata[ser_pkg::SEQ_RUN_BIT] == $past(sequencer_running))
		else $error("running bit wrong");
	one_cause_a: assert property (reg_rd && reg_addr == ser_pkg::ADDR_SEQ_STATUS
		|=> $onehot0(reg_rdata[2:0])) else $error("more than one halt cause");
	ecc_summary_a: assert property (reg_rd && reg_addr == ser_pkg::ADDR_ECC_STATUS
		|=> reg_rdata[7] == (reg_rdata[4:0] != 5'h00)) else $error("summary bit wrong");
	// The interrupt may only rise after an event or a change of the enable mask.
	irq_cause_a: assert property ($rose(irq) |-> $past(seq_evt.halt || seq_evt.sector_done
		|| (reg_wr && reg_addr == ser_pkg::ADDR_IRQ_ENABLE)))
		else $error("interrupt rose without a cause");
endmodule : ser_error_recovery_checker
bind ser_error_recovery ser_error_recovery_checker #(.NUM_IL(NUM_IL), .MAX_DEG(MAX_DEG))
	ser_error_recovery_checker_inst (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .seq_evt, .seq_start, .restart_addr, .sequencer_running, .irq);
`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// =====
// Bench top: sequencer stimulus, host model and checks.
module testbench;
	logic sys_clk;
	logic rst_b;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	ser_pkg::ser_evt_s seq_evt;
	logic [7:0] id_sector_in;
	logic synd_load;
	logic [239:0] synd_in;
	logic [4:0] synd_err_in;
	logic seq_start;
	logic [7:0] restart_addr;
	logic sequencer_running;
	logic irq;
	int error_cnt = 0;
	int checks = 0;

	ser_error_recovery ser_error_recovery_inst (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .seq_evt, .id_sector_in, .synd_load, .synd_in, .synd_err_in,
		.seq_start, .restart_addr, .sequencer_running, .irq);
	ser_host_model ser_host_model_inst (.sys_clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd);

	// Clock of 4 ns.
	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic results;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : results

	// One-cycle sequencer event; the failing sector is always 0x20.
	task automatic ev(input logic dn, input logic hl, input ser_pkg::ser_err_e c, input logic x);
		@(posedge sys_clk);
		seq_evt <= '{dn, hl, c, x};
		id_sector_in <= 8'h20;
		@(posedge sys_clk);
		seq_evt <= '0;
	endtask : ev

	// Halt mid-command, check the left state, then restart and finish the command.
	task automatic t_halt(input ser_pkg::ser_err_e c, input logic x);
		logic [7:0] d;
		logic [7:0] n;
		logic [7:0] id;
		logic [7:0] st;
		n = ((c == ser_pkg::SER_ERR_ID || c == ser_pkg::SER_ERR_SYNC) && !x) ? 8'h03 : 8'h02;
		id = (c == ser_pkg::SER_ERR_SYNC && !x) ? 8'h20 : 8'h21;
		// An ID halt latches none of the three cause flags.
		st = (c == ser_pkg::SER_ERR_SYNC) ? 8'h01 : (c == ser_pkg::SER_ERR_CMP) ? 8'h02
			: (c == ser_pkg::SER_ERR_CKS) ? 8'h04 : 8'h00;
		ser_host_model_inst.wr(ser_pkg::ADDR_SECT_COUNT, 8'h03);
		ev(1'b0, 1'b1, c, x);
		@(posedge sys_clk);
		#1;
		chk("irq_halt", 8'h01, {7'h00, irq});
		ser_host_model_inst.rd(ser_pkg::ADDR_SECT_COUNT, d);
		chk("sect_count", n, d);
		ser_host_model_inst.wr(ser_pkg::ADDR_SECT_COUNT, n);
		#1;
		chk("no_restart", 8'h00, {7'h00, sequencer_running});
		chk("no_start", 8'h00, {7'h00, seq_start});
		ser_host_model_inst.rd(ser_pkg::ADDR_ID_SECTOR, d);
		chk("id_sector", id, d);
		ser_host_model_inst.rd(ser_pkg::ADDR_SEQ_STATUS, d);
		chk("halt_cause", st, d);
		ser_host_model_inst.wr(ser_pkg::ADDR_IRQ_CLEAR, 8'h01);
		@(posedge sys_clk);
		#1;
		chk("irq_cleared", 8'h00, {7'h00, irq});
		ser_host_model_inst.wr(ser_pkg::ADDR_RESTART, 8'h40);
		#1;
		chk("restarted", 8'h01, {7'h00, sequencer_running});
		chk("start_pulse", 8'h01, {7'h00, seq_start});
		chk("restart_addr", 8'h40, restart_addr);
		ser_host_model_inst.rd(ser_pkg::ADDR_SEQ_STATUS, d);
		chk("flags_cleared", 8'h08, d);
		repeat (n) ev(1'b1, 1'b0, ser_pkg::SER_ERR_NONE, 1'b1);
		@(posedge sys_clk);
		#1;
		chk("stopped", 8'h00, {7'h00, sequencer_running});
		chk("irq_masked", 8'h00, {7'h00, irq});
		ser_host_model_inst.rd(ser_pkg::ADDR_IRQ_STATUS, d);
		chk("irq_status", 8'h02, d);
		ser_host_model_inst.wr(ser_pkg::ADDR_IRQ_CLEAR, 8'h02);
		$display("test halt cause %0d xfer %0d done", c, x);
	endtask : t_halt

	// Interleaves 1, 2 and 4 fail; each byte holds its slot and index.
	task automatic t_synd(input int deg);
		logic [7:0] e;
		logic [7:0] b [8];
		logic [7:0] ex [3] = '{8'h96, 8'h94, 8'h90};
		int il [3] = '{1, 2, 4};
		ser_host_model_inst.wr(ser_pkg::ADDR_ECC_CONFIG, (deg == 6) ? 8'h01 : 8'h00);
		@(posedge sys_clk);
		synd_load <= 1'b1;
		synd_err_in <= 5'b10110;
		@(posedge sys_clk);
		synd_load <= 1'b0;
		for (int k = 0; k < 3; k++)
		begin
			ser_host_model_inst.fetch(deg, 1, e, b);
			chk("ecc_status", ex[k], e);
			for (int j = 0; j <= deg; j++)
				chk("syndrome", {il[k][3:0], 4'((j < deg) ? j : deg - 1)}, b[j]);
		end
		ser_host_model_inst.rd(ser_pkg::ADDR_ECC_STATUS, e);
		chk("ecc_empty", 8'h00, e);
		ser_host_model_inst.rd(ser_pkg::ADDR_SYND_PORT, e);
		chk("port_empty", 8'h00, e);
		$display("test syndromes degree %0d done", deg);
	endtask : t_synd

	// Main sequence.
	initial
	begin
		rst_b = 1'b0;
		seq_evt = '0;
		id_sector_in = 8'h00;
		synd_load = 1'b0;
		synd_err_in = 5'h00;
		for (int i = 0; i < 30; i++)
			synd_in[i*8+:8] = {4'(i / 6), 4'(i % 6)};
		repeat (6) @(posedge sys_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge sys_clk);
		ser_host_model_inst.wr(ser_pkg::ADDR_IRQ_ENABLE, 8'h01);
		for (int i = 1; i <= 4; i++)
		begin
			t_halt(ser_pkg::ser_err_e'(3'(i)), 1'b0);
			t_halt(ser_pkg::ser_err_e'(3'(i)), 1'b1);
		end
		t_synd(6);
		t_synd(5);
		results();
	end

	// A hang is cut short well past the few hundred cycles the tests need.
	initial
	begin
		#200000;
		error_cnt++;
		results();
	end
endmodule : testbench
`default_nettype wire
